// ==== rf_protocol_mode_config_bench.sv ====
// Self-checking bench for the protocol mode configuration bank.
// Assumes the bank and the host model share one 100 MHz core clock.
`timescale 1ns/1ns
module rf_protocol_mode_config_bench;
	typedef struct {int k; logic [7:0] v;} rpm_note_type;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic cmd_set_default = 1'b0;
	logic cmd_go_normal = 1'b0;
	logic [7:0] normal_speed = 8'h00;
	logic op_tx_en = 1'b1;
	logic op_rx_en = 1'b1;
	logic field_present = 1'b1;
	logic [7:0] reg_rdata, transport_start_byte, ca_seen;
	logic role_target, mode_supported, tx_enable, rx_enable;
	logic [3:0] protocol_sel;
	logic [1:0] send_speed, recv_speed;
	logic tx_no_parity, rx_raw, transport_frame_prefix, anticoll_frame;
	logic [5:0] pause_width;
	logic pause_width_valid, collision_avoid_start;
	int n_errors = 0;
	int compares = 0;
	rpm_note_type notes[$];
	rpm_note_type cur;
	event chk_ev;

	rpm_config_regs u_dut (
		.core_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .cmd_set_default,
		.cmd_go_normal, .normal_speed, .op_tx_en, .op_rx_en, .field_present,
		.reg_rdata, .role_target, .protocol_sel, .mode_supported, .tx_enable,
		.rx_enable, .send_speed, .recv_speed, .tx_no_parity, .rx_raw,
		.transport_frame_prefix, .transport_start_byte, .pause_width,
		.pause_width_valid, .anticoll_frame, .collision_avoid_start
	);

	rpm_host_model u_host (.core_clk, .reg_addr, .reg_wr, .reg_wdata);

	// Free-running core clock
	always #5 core_clk = ~core_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic note(input int k, input logic [7:0] v);
		notes.push_back('{k, v});
		-> chk_ev;
	endtask

	task automatic report(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		report(got, exp);
	endtask

	task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
		report(got, exp);
	endtask

	task automatic cmp_width(input logic [7:0] got, input logic [7:0] exp);
		report(got, exp);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		u_host.write_reg(a, d);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		u_host.point(a);
		note(0, exp);
	endtask

	task automatic close_out();
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Takes every queued note off, oldest first, and compares each with the outputs
	initial forever begin
		@(chk_ev);
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			case (cur.k)
				0: cmp_byte(reg_rdata, cur.v);
				1: cmp_flags({role_target, protocol_sel, mode_supported,
					tx_enable, rx_enable}, cur.v);
				2: cmp_flags({send_speed, recv_speed, tx_enable, rx_enable,
					2'h0}, cur.v);
				3: cmp_width({1'b0, pause_width_valid, pause_width}, cur.v);
				4: cmp_flags({tx_no_parity, rx_raw, transport_frame_prefix,
					anticoll_frame, 4'h0}, cur.v);
				5: cmp_byte(transport_start_byte, cur.v);
				default: cmp_flags(ca_seen, cur.v);
			endcase
		end
	end

	// Cuts a hang short well beyond the expected run length
	initial begin
		#100000;
		n_errors++;
		close_out();
	end

	// Main sequence
	initial begin
		int m;
		logic [3:0] sl;
		logic sup;
		logic [7:0] d;
		void'($urandom(63));
		tick(12);
		rstn = 1'b1;
		tick(1);
		rd(6'h03, 8'h08); // Mode default
		rd(6'h04, 8'h00); // Speed default
		rd(6'h05, 8'h00); // Framing default
		rd(6'h06, 8'h00); // Unmapped reads zero
		wr(6'h03, 8'hFF);
		rd(6'h03, 8'hF9); // Unused mode bits stay zero
		// Every role and mode code, with random operation enables
		for (m = 0; m < 32; m++) begin
			op_tx_en = 1'($urandom);
			op_rx_en = 1'($urandom);
			wr(6'h03, {m[4:0], 3'h0});
			sl = m[3:0];
			sup = m[4] ? (sl <= 4'h1) : (sl <= 4'h4 || sl >= 4'hE);
			d = {m[4:0], sup, op_tx_en & sup, op_rx_en & sup};
			note(1, d);
		end
		// Every send code, then every receive code, in Type A
		op_tx_en = 1'b1;
		op_rx_en = 1'b1;
		wr(6'h03, 8'h08);
		for (m = 0; m < 32; m++) begin
			sl = m[3:0];
			d = (m < 16) ? {sl, 4'h0} : {4'h2, sl};
			wr(6'h04, d);
			sup = (d[7:4] <= 4'h3) && (d[3:0] <= 4'h3);
			note(2, {d[5:4], d[1:0], sup, sup, 2'h0}); // Rates
		end
		// Speed load command in a mode without split rates
		wr(6'h03, 8'h00);
		normal_speed = 8'h21;
		cmd_go_normal = 1'b1;
		tick(1);
		cmd_go_normal = 1'b0;
		tick(1);
		rd(6'h04, 8'h21); // Speed loaded by command
		note(2, 8'hAC); // Receive follows send
		// Pause widths at carrier/128 for all codes
		wr(6'h03, 8'h08);
		wr(6'h04, 8'h00);
		for (m = 0; m < 16; m++) begin
			sl = m[3:0];
			wr(6'h05, {3'h0, sl, 1'b0});
			d = {2'h1, (sl[3] ? 6'h1B : 6'h23) + {3'h0, sl[2:0]}};
			note(3, d); // Width in carrier periods
		end
		// Carrier/16 and carrier/64 edge codes
		wr(6'h04, 8'h33);
		wr(6'h05, 8'h06);
		note(3, 8'h48); // Code 3 gives 8 periods
		wr(6'h05, 8'h08);
		note(3, 8'h00); // Code 4 not valid here
		wr(6'h04, 8'h11);
		note(3, 8'h56); // Code 4 folds back to 22 at carrier/64
		wr(6'h05, 8'h0E);
		note(3, 8'h00); // Code 7 not valid at carrier/64
		// Random framing bits in Type A; no transmit command is issued
		for (m = 0; m < 4; m++) begin
			d = 8'($urandom);
			wr(6'h05, d);
			note(4, {d[7:5], d[0], 4'h0}); // Framing
			note(5, 8'hF0); // Start byte value
			rd(6'h05, d); // Framing readback
		end
		// Default command restores all three registers
		wr(6'h03, 8'hB1);
		wr(6'h04, 8'h12);
		cmd_set_default = 1'b1;
		tick(1);
		cmd_set_default = 1'b0;
		tick(1);
		rd(6'h03, 8'h08); // Mode back to default
		rd(6'h04, 8'h00); // Speed back to default
		rd(6'h05, 8'h00); // Framing back to default
		// Field drop with the auto bit clear, then set
		for (m = 0; m < 2; m++) begin
			wr(6'h03, {7'h04, m[0]});
			ca_seen = 8'h00;
			field_present = 1'b0;
			repeat (8) begin
				tick(1);
				ca_seen = ca_seen + {7'h00, collision_avoid_start};
			end
			note(6, {7'h00, m[0]}); // One start pulse only when enabled
			field_present = 1'b1;
			tick(4);
		end
		// Mid-run reset restores defaults and clears the derived outputs
		wr(6'h03, 8'hB1);
		rstn = 1'b0;
		tick(2);
		note(1, 8'h00); // Outputs cleared in reset
		rstn = 1'b1;
		tick(1);
		rd(6'h03, 8'h08); // Mode default after reset
		close_out();
	end

endmodule // rf_protocol_mode_config_bench

// ==== rpm_config_regs.sv ====
// Protocol mode, link speed and Type A framing configuration registers.
// Assumes the serial command decoder drives the register port and the
// command pulses on core_clk; field_present comes from an analog pin.
//
// Overview of operation
// - Mode bit 7 low selects initiator, high target; role decides mode field.
// - Initiator mode field picks peer, Type A/B, proprietary, tag or streams.
// - Target mode field picks peer with rate detection or peer normal mode.
// - Any unsupported operating mode code disables transmit and receive.
// - All three registers return to defaults at power-up and on Set Default.
// - Auto bit starts response collision avoidance when external field drops.
// - Send rate code 0..3 gives carrier/128, /64, /32, /16; others unused.
// - Receive rate uses same coding; applies only where rates may differ.
// - Any unsupported bit-rate code disables transmit and receive.
// - Go to Normal NFC Mode command loads new link speed contents.
// - Send parity suppression sends FIFO data without any parity bits.
// - Raw receive bit skips parity and CRC; host clears it outside Type A.
// - Transport frame bit adds F0 and length on send, strips F0 on receive.
// - Four-bit pause width field sets Type A pause in carrier periods.
// - At carrier/128 codes 0111..0000..1000 give 42..35..27 periods.
// - Transmit and receive run only while operation control enables are set.
`timescale 1ns/1ns
module rpm_config_regs (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [5:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic cmd_set_default,
	input wire logic cmd_go_normal,
	input wire logic [7:0] normal_speed,
	input wire logic op_tx_en,
	input wire logic op_rx_en,
	input wire logic field_present,
	output logic [7:0] reg_rdata,
	output logic role_target,
	output logic [3:0] protocol_sel,
	output logic mode_supported,
	output logic tx_enable,
	output logic rx_enable,
	output logic [1:0] send_speed,
	output logic [1:0] recv_speed,
	output logic tx_no_parity,
	output logic rx_raw,
	output logic transport_frame_prefix,
	output logic [7:0] transport_start_byte,
	output logic [5:0] pause_width,
	output logic pause_width_valid,
	output logic anticoll_frame,
	output logic collision_avoid_start
);

	rpm_pw_if pw ();

	logic [7:0] mode_r, mode_nxt;
	logic [7:0] speed_r, speed_nxt;
	logic [7:0] typea_r, typea_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic fld_s1_r, fld_s2_r, fld_prev_r;
	logic role_r, supp_r, txe_r, rxe_r, txp_r, rxr_r, tfp_r, anti_r, cas_r;
	logic [3:0] sel_r;
	logic [1:0] ss_r, rs_r;
	logic [5:0] pw_r;
	logic pwv_r;
	logic [7:0] tsb_r;
	logic role_nxt, supp_nxt, txe_nxt, rxe_nxt, txp_nxt, rxr_nxt, tfp_nxt;
	logic anti_nxt, cas_nxt;
	logic [3:0] sel_nxt;
	logic [1:0] ss_nxt, rs_nxt;
	logic [5:0] pw_nxt;
	logic pwv_nxt;
	logic [7:0] tsb_nxt;
	logic mode_ok, speed_ok, split_rates, field_off_edge;
	logic [3:0] sel_code, send_code, recv_code;

	// Field decode of the stored registers
	assign sel_code = mode_r[rpm_pkg::MODE_SEL_HI:rpm_pkg::MODE_SEL_LO];
	assign send_code = speed_r[rpm_pkg::SEND_SPEED_HI:rpm_pkg::SEND_SPEED_LO];
	assign recv_code = speed_r[rpm_pkg::RECV_SPEED_HI:rpm_pkg::RECV_SPEED_LO];
	assign field_off_edge = fld_prev_r && !fld_s2_r;

	// Mode code check per role
	always_comb begin
		mode_ok = 1'b0;
		if (mode_r[rpm_pkg::MODE_ROLE_BIT]) begin
			case (sel_code)
				rpm_pkg::TARG_PEER_RATE_DETECT: mode_ok = 1'b1;
				rpm_pkg::TARG_PEER_NORMAL: mode_ok = 1'b1;
				default: mode_ok = 1'b0;
			endcase
		end else begin
			case (sel_code)
				rpm_pkg::INIT_PEER_ACTIVE: mode_ok = 1'b1;
				rpm_pkg::INIT_TYPE_A: mode_ok = 1'b1;
				rpm_pkg::INIT_TYPE_B: mode_ok = 1'b1;
				rpm_pkg::INIT_PROP_212_424: mode_ok = 1'b1;
				rpm_pkg::INIT_TYPE_1_TAG: mode_ok = 1'b1;
				rpm_pkg::INIT_SUBC_STREAM: mode_ok = 1'b1;
				rpm_pkg::INIT_BPSK_STREAM: mode_ok = 1'b1;
				default: mode_ok = 1'b0;
			endcase
		end
	end

	// Rate codes above fc/16 are unused
	assign speed_ok = (send_code <= rpm_pkg::SPEED_MAX_CODE)
		&& (recv_code <= rpm_pkg::SPEED_MAX_CODE);
	// Only Type A and Type B initiators run split send/receive rates
	assign split_rates = !mode_r[rpm_pkg::MODE_ROLE_BIT]
		&& ((sel_code == rpm_pkg::INIT_TYPE_A)
		|| (sel_code == rpm_pkg::INIT_TYPE_B));

	// Pause width lookup at the current send rate
	assign pw.code = typea_r[rpm_pkg::PAUSE_WIDTH_HI:rpm_pkg::PAUSE_WIDTH_LO];
	assign pw.rate = send_code[1:0];

	rpm_pulse_width u_pw (
		.pw(pw)
	);

	// Register file next values; default beats normal load beats write
	always_comb begin
		mode_nxt = mode_r;
		speed_nxt = speed_r;
		typea_nxt = typea_r;
		if (!rstn || cmd_set_default) begin
			mode_nxt = rpm_pkg::PROTOCOL_MODE_RST;
			speed_nxt = rpm_pkg::LINK_SPEED_RST;
			typea_nxt = rpm_pkg::TYPE_A_FRAMING_RST;
		end else if (cmd_go_normal) begin
			speed_nxt = normal_speed;
		end else if (reg_wr) begin
			if (reg_addr == rpm_pkg::ADDR_PROTOCOL_MODE) begin
				mode_nxt = reg_wdata & rpm_pkg::PROTOCOL_MODE_MASK;
			end else if (reg_addr == rpm_pkg::ADDR_LINK_SPEED) begin
				speed_nxt = reg_wdata;
			end else if (reg_addr == rpm_pkg::ADDR_TYPE_A_FRAMING) begin
				typea_nxt = reg_wdata;
			end
		end
	end

	// Read data, one cycle after the address; unmapped reads zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (!rstn) begin
			rdata_nxt = 8'h00;
		end else if (reg_addr == rpm_pkg::ADDR_PROTOCOL_MODE) begin
			rdata_nxt = mode_r;
		end else if (reg_addr == rpm_pkg::ADDR_LINK_SPEED) begin
			rdata_nxt = speed_r;
		end else if (reg_addr == rpm_pkg::ADDR_TYPE_A_FRAMING) begin
			rdata_nxt = typea_r;
		end
	end

	// Control outputs derived from the stored settings
	always_comb begin
		role_nxt = mode_r[rpm_pkg::MODE_ROLE_BIT];
		sel_nxt = sel_code;
		supp_nxt = mode_ok && speed_ok;
		txe_nxt = op_tx_en && mode_ok && speed_ok;
		rxe_nxt = op_rx_en && mode_ok && speed_ok;
		ss_nxt = send_code[1:0];
		rs_nxt = split_rates ? recv_code[1:0] : send_code[1:0];
		txp_nxt = typea_r[rpm_pkg::TX_NO_PARITY_BIT];
		rxr_nxt = typea_r[rpm_pkg::RX_RAW_BIT];
		tfp_nxt = typea_r[rpm_pkg::TRANSPORT_FRAME_BIT];
		tsb_nxt = rpm_pkg::TRANSPORT_START_BYTE;
		pw_nxt = pw.width;
		pwv_nxt = pw.valid;
		anti_nxt = typea_r[rpm_pkg::ANTICOLL_BIT];
		cas_nxt = field_off_edge && mode_r[rpm_pkg::MODE_AUTO_CA_BIT];
		if (!rstn) begin
			role_nxt = 1'b0;
			sel_nxt = 4'h0;
			supp_nxt = 1'b0;
			txe_nxt = 1'b0;
			rxe_nxt = 1'b0;
			ss_nxt = 2'h0;
			rs_nxt = 2'h0;
			txp_nxt = 1'b0;
			rxr_nxt = 1'b0;
			tfp_nxt = 1'b0;
			tsb_nxt = 8'h00;
			pw_nxt = 6'h00;
			pwv_nxt = 1'b0;
			anti_nxt = 1'b0;
			cas_nxt = 1'b0;
		end
	end

	// All state registered; reset folded into the next values
	always_ff @(posedge core_clk) begin
		mode_r <= mode_nxt;
		speed_r <= speed_nxt;
		typea_r <= typea_nxt;
		rdata_r <= rdata_nxt;
		fld_s1_r <= field_present;
		fld_s2_r <= fld_s1_r;
		fld_prev_r <= fld_s2_r;
		role_r <= role_nxt;
		sel_r <= sel_nxt;
		supp_r <= supp_nxt;
		txe_r <= txe_nxt;
		rxe_r <= rxe_nxt;
		ss_r <= ss_nxt;
		rs_r <= rs_nxt;
		txp_r <= txp_nxt;
		rxr_r <= rxr_nxt;
		tfp_r <= tfp_nxt;
		tsb_r <= tsb_nxt;
		pw_r <= pw_nxt;
		pwv_r <= pwv_nxt;
		anti_r <= anti_nxt;
		cas_r <= cas_nxt;
	end

	// Outputs straight from flops
	assign reg_rdata = rdata_r;
	assign role_target = role_r;
	assign protocol_sel = sel_r;
	assign mode_supported = supp_r;
	assign tx_enable = txe_r;
	assign rx_enable = rxe_r;
	assign send_speed = ss_r;
	assign recv_speed = rs_r;
	assign tx_no_parity = txp_r;
	assign rx_raw = rxr_r;
	assign transport_frame_prefix = tfp_r;
	assign transport_start_byte = tsb_r;
	assign pause_width = pw_r;
	assign pause_width_valid = pwv_r;
	assign anticoll_frame = anti_r;
	assign collision_avoid_start = cas_r;

	// Checks on the configuration behaviour
	AST_ROLE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> role_target == $past(mode_r[rpm_pkg::MODE_ROLE_BIT]))
		else $error("role output does not follow mode bit 7");
	AST_BAD_MODE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && !$past(mode_ok) |-> !tx_enable && !rx_enable)
		else $error("tx or rx enabled with unsupported mode");
	AST_TARGET_CODES: assert property (
		@(posedge core_clk) disable iff (!rstn)
		mode_r[rpm_pkg::MODE_ROLE_BIT]
		&& (sel_code > rpm_pkg::TARG_PEER_NORMAL) |=> !mode_supported)
		else $error("target mode code above 1 reported supported");
	AST_INIT_CODES: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!mode_r[rpm_pkg::MODE_ROLE_BIT]
		&& (sel_code > rpm_pkg::INIT_TYPE_1_TAG)
		&& (sel_code < rpm_pkg::INIT_SUBC_STREAM) |=> !mode_supported)
		else $error("initiator mode code 5 to D reported supported");
	AST_BAD_RATE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && (($past(send_code) > rpm_pkg::SPEED_MAX_CODE)
		|| ($past(recv_code) > rpm_pkg::SPEED_MAX_CODE))
		|-> !tx_enable && !rx_enable)
		else $error("tx or rx enabled with unsupported rate");
	AST_DEFAULTS: assert property (
		@(posedge core_clk) disable iff (!rstn)
		cmd_set_default |=> mode_r == rpm_pkg::PROTOCOL_MODE_RST
		&& speed_r == rpm_pkg::LINK_SPEED_RST
		&& typea_r == rpm_pkg::TYPE_A_FRAMING_RST)
		else $error("set default did not restore registers");
	AST_NORMAL_LOAD: assert property (
		@(posedge core_clk) disable iff (!rstn)
		cmd_go_normal && !cmd_set_default |=> speed_r == $past(normal_speed))
		else $error("normal mode command did not load speed");
	AST_AUTO_CA: assert property (
		@(posedge core_clk) disable iff (!rstn)
		field_off_edge
		|=> collision_avoid_start == $past(mode_r[rpm_pkg::MODE_AUTO_CA_BIT]))
		else $error("collision avoidance start wrong on field off");
	AST_CA_EDGE_ONLY: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!field_off_edge |=> !collision_avoid_start)
		else $error("collision avoidance start without field off");
	AST_UNUSED_BITS: assert property (
		@(posedge core_clk) disable iff (!rstn)
		reg_wr && reg_addr == rpm_pkg::ADDR_PROTOCOL_MODE
		&& !cmd_set_default && !cmd_go_normal
		|=> mode_r == ($past(reg_wdata) & rpm_pkg::PROTOCOL_MODE_MASK))
		else $error("mode write kept unused bits");
	AST_ENABLES: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && !$past(op_tx_en) |-> !tx_enable)
		else $error("tx enabled without operation control bit");
	AST_RX_ENABLES: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && !$past(op_rx_en) |-> !rx_enable)
		else $error("rx enabled without operation control bit");
	AST_TX_PARITY: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn)
		|-> tx_no_parity == $past(typea_r[rpm_pkg::TX_NO_PARITY_BIT]))
		else $error("parity suppression output does not follow bit 7");
	AST_RX_RAW: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rx_raw == $past(typea_r[rpm_pkg::RX_RAW_BIT]))
		else $error("raw receive output does not follow bit 6");
	AST_TRANSPORT: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> transport_start_byte == rpm_pkg::TRANSPORT_START_BYTE
		&& transport_frame_prefix
		== $past(typea_r[rpm_pkg::TRANSPORT_FRAME_BIT]))
		else $error("transport frame outputs wrong");
	AST_PAUSE_42: assert property (
		@(posedge core_clk) disable iff (!rstn)
		typea_r[4:1] == 4'h7 && speed_r[7:4] == 4'h0 |=> pause_width == 6'h2A)
		else $error("code 0111 at fc/128 not 42 periods");
	AST_PAUSE_27: assert property (
		@(posedge core_clk) disable iff (!rstn)
		typea_r[4:1] == 4'h8 && speed_r[7:4] == 4'h0 |=> pause_width == 6'h1B)
		else $error("code 1000 at fc/128 not 27 periods");
	AST_PAUSE_FC64: assert property (
		@(posedge core_clk) disable iff (!rstn)
		typea_r[4:1] == 4'h4 && speed_r[7:4] == 4'h1 |=> pause_width == 6'h16)
		else $error("code 0100 at fc/64 not 22 periods");
	AST_RX_RATE: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!split_rates |=> recv_speed == send_speed)
		else $error("receive rate split in a single-rate protocol");

endmodule // rpm_config_regs

// ==== rpm_host_model.sv ====
// Host model that reaches the configuration bank over its register port.
// Assumes callers enter its tasks just after a rising edge of core_clk.
`timescale 1ns/1ns
module rpm_host_model (
	input wire logic core_clk,
	output logic [5:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);

	// Idle port at time zero
	initial begin
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end

	// One write, then an idle edge so the strobe never toggles in one step
	task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d; // Released data no longer shows the last value
		@(posedge core_clk);
		#1;
	endtask

	// Points at a register and waits until its value has reached rdata
	task automatic point(input logic [5:0] a);
		reg_addr = a;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

endmodule // rpm_host_model

// ==== rpm_pkg.sv ====
// Package for the protocol mode configuration bank.
// Holds register offsets, field positions, reset values and mode codes.
// Assumes a single core clock domain; nothing here is clocked.
package rpm_pkg;

	// Register offsets on the internal register port
	localparam logic [5:0] ADDR_PROTOCOL_MODE = 6'h03;
	localparam logic [5:0] ADDR_LINK_SPEED = 6'h04;
	localparam logic [5:0] ADDR_TYPE_A_FRAMING = 6'h05;

	// Reset values, loaded at power-up and by the default command
	localparam logic [7:0] PROTOCOL_MODE_RST = 8'h08;
	localparam logic [7:0] LINK_SPEED_RST = 8'h00;
	localparam logic [7:0] TYPE_A_FRAMING_RST = 8'h00;

	// Protocol mode register fields
	localparam int MODE_ROLE_BIT = 7;
	localparam int MODE_SEL_HI = 6;
	localparam int MODE_SEL_LO = 3;
	localparam int MODE_AUTO_CA_BIT = 0;
	// Bits 2 and 1 are unused and always zero
	localparam logic [7:0] PROTOCOL_MODE_MASK = 8'hF9;

	// Link speed register fields
	localparam int SEND_SPEED_HI = 7;
	localparam int SEND_SPEED_LO = 4;
	localparam int RECV_SPEED_HI = 3;
	localparam int RECV_SPEED_LO = 0;
	localparam logic [3:0] SPEED_MAX_CODE = 4'h3;

	// Type A framing register fields
	localparam int TX_NO_PARITY_BIT = 7;
	localparam int RX_RAW_BIT = 6;
	localparam int TRANSPORT_FRAME_BIT = 5;
	localparam int PAUSE_WIDTH_HI = 4;
	localparam int PAUSE_WIDTH_LO = 1;
	localparam int ANTICOLL_BIT = 0;
	localparam logic [7:0] TRANSPORT_START_BYTE = 8'hF0;

	// Initiator operating mode codes
	localparam logic [3:0] INIT_PEER_ACTIVE = 4'h0;
	localparam logic [3:0] INIT_TYPE_A = 4'h1;
	localparam logic [3:0] INIT_TYPE_B = 4'h2;
	localparam logic [3:0] INIT_PROP_212_424 = 4'h3;
	localparam logic [3:0] INIT_TYPE_1_TAG = 4'h4;
	localparam logic [3:0] INIT_SUBC_STREAM = 4'hE;
	localparam logic [3:0] INIT_BPSK_STREAM = 4'hF;

	// Target operating mode codes
	localparam logic [3:0] TARG_PEER_RATE_DETECT = 4'h0;
	localparam logic [3:0] TARG_PEER_NORMAL = 4'h1;

	// Bit rate codes
	localparam logic [1:0] RATE_FC128 = 2'h0;
	localparam logic [1:0] RATE_FC64 = 2'h1;
	localparam logic [1:0] RATE_FC32 = 2'h2;
	localparam logic [1:0] RATE_FC16 = 2'h3;

	// Pause width base values in carrier periods, code 0000 per rate
	localparam logic [5:0] PAUSE_BASE_FC128 = 6'h23;
	localparam logic [5:0] PAUSE_BASE_FC64 = 6'h12;
	localparam logic [5:0] PAUSE_BASE_FC32 = 6'h09;
	localparam logic [5:0] PAUSE_BASE_FC16 = 6'h05;
	// Widths of the three fc/64 codes that fold back from 22
	localparam logic [5:0] PAUSE_FC64_C4 = 6'h16;
	localparam logic [5:0] PAUSE_FC64_C5 = 6'h15;
	localparam logic [5:0] PAUSE_FC64_C6 = 6'h14;

endpackage

// ==== rpm_pulse_width.sv ====
// Combinational map from pause width code and bit rate to carrier periods.
// Assumes the caller registers the result.
`timescale 1ns/1ns
module rpm_pulse_width (
	rpm_pw_if.lookup pw
);

	logic signed [4:0] offs;
	logic [5:0] base;

	// Code is a signed offset from the rate's base width
	always_comb begin
		offs = {pw.code[3], pw.code};
		base = rpm_pkg::PAUSE_BASE_FC128;
		pw.valid = 1'b0;
		pw.width = 6'h00;
		case (pw.rate)
			rpm_pkg::RATE_FC128: begin
				base = rpm_pkg::PAUSE_BASE_FC128;
				pw.valid = 1'b1;
			end
			rpm_pkg::RATE_FC64: begin
				base = rpm_pkg::PAUSE_BASE_FC64;
				pw.valid = (offs >= -5'sd6) && (offs <= 5'sd6);
			end
			rpm_pkg::RATE_FC32: begin
				base = rpm_pkg::PAUSE_BASE_FC32;
				pw.valid = (offs >= -5'sd4) && (offs <= 5'sd4);
			end
			default: begin
				base = rpm_pkg::PAUSE_BASE_FC16;
				pw.valid = (offs >= -5'sd3) && (offs <= 5'sd3);
			end
		endcase
		pw.width = 6'(base + 6'(offs));
		// fc/64 folds back above code 0011
		if (pw.rate == rpm_pkg::RATE_FC64) begin
			if (pw.code == 4'h4) begin
				pw.width = rpm_pkg::PAUSE_FC64_C4;
			end else if (pw.code == 4'h5) begin
				pw.width = rpm_pkg::PAUSE_FC64_C5;
			end else if (pw.code == 4'h6) begin
				pw.width = rpm_pkg::PAUSE_FC64_C6;
			end
		end
		if (!pw.valid) begin
			pw.width = 6'h00;
		end
	end

endmodule // rpm_pulse_width

// ==== rpm_pw_if.sv ====
// Interface between the register bank and the pause width lookup.
// Assumes the lookup is purely combinational.
`timescale 1ns/1ns
interface rpm_pw_if;
	logic [3:0] code;
	logic [1:0] rate;
	logic [5:0] width;
	logic valid;

	modport lookup (input code, input rate, output width, output valid);
	modport user (output code, output rate, input width, input valid);
endinterface // rpm_pw_if
